// [rtmco_pkg.sv]
// constants and types for the remote terminal mode command option logic
// Contract
// - auto shutdown off: host handles codes 20, 21
// - sync option 11: always load time tag
// - sync option 00: no load, status still sent
// - sync option 01: load when data bit0 0
// - sync option 10: load when data bit0 1
// - time tag loads before status word starts
// - load targets receiving terminal's own counter
// - vector option 0: clear service request first
// - reset option 0: soft reset after status
// - undefined codes invalid when option set
package rtmco_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // register map
   localparam logic [7:0] REG_CFG = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h02;
   localparam logic [7:0] REG_TT_RT1 = 8'h47;
   localparam logic [7:0] REG_TT_RT2 = 8'h49;

   // configuration fields
   localparam int CFG_RST_OPT = 0;
   localparam int CFG_VEC_OPT = 1;
   localparam int CFG_SYNC_LO = 2;
   localparam int CFG_SYNC_HI = 3;
   localparam int CFG_ABSD = 4;
   localparam int CFG_UMC = 9;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] CFG_WMASK = 16'h021F;

   // status fields
   localparam int STAT_TXDIS_LO = 0;
   localparam int STAT_TXDIS_HI = 1;
   localparam int STAT_BUSY = 2;

   localparam logic [15:0] TT_RESET = 16'h0000;
   localparam logic [15:0] ZERO_WORD = 16'h0000;

   // sync load option codes
   localparam logic [1:0] SYNC_NONE = 2'h0;
   localparam logic [1:0] SYNC_EVEN = 2'h1;
   localparam logic [1:0] SYNC_ODD = 2'h2;
   localparam logic [1:0] SYNC_ALWAYS = 2'h3;

   // mode codes
   localparam logic [4:0] MC_RESET = 5'h08;
   localparam logic [4:0] MC_LOW_LAST = 5'h0F;
   localparam logic [4:0] MC_VECTOR = 5'h10;
   localparam logic [4:0] MC_SYNC_DATA = 5'h11;
   localparam logic [4:0] MC_LAST_CMD = 5'h12;
   localparam logic [4:0] MC_BIT_WORD = 5'h13;
   localparam logic [4:0] MC_SHUTDOWN = 5'h14;
   localparam logic [4:0] MC_OVERRIDE = 5'h15;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ACT = 5'b00010,
      ST_STAT = 5'b00100,
      ST_WAIT = 5'b01000,
      ST_SRST = 5'b10000
   } rtmco_state_t;
endpackage

// [rtmco_ttag.sv]
// per-terminal 16-bit time-tag counters with load port
`timescale 1ns/1ps
`default_nettype none
module rtmco_ttag
   import rtmco_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [1:0] tick,
   input wire logic [1:0] load,
   input wire logic [15:0] load_data,
   output logic [1:0][15:0] count
);
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_term
         // a load beats a tick in the same cycle so the synced value is exact
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               count[i] <= TT_RESET;
            end else if (load[i]) begin
               count[i] <= load_data;
            end else if (tick[i]) begin
               count[i] <= count[i] + 16'h0001;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [rtmco_top.sv]
// mode command automatic option logic for two remote terminals
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rtmco_top
   import rtmco_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic mc_valid,
   input wire logic mc_rt,
   input wire logic [4:0] mc_code,
   input wire logic mc_tr,
   input wire logic mc_broadcast,
   input wire logic mc_bus,
   input wire logic [15:0] mc_data,
   input wire logic status_done,
   input wire logic [1:0] tt_tick,
   output logic status_go,
   output logic srq_clear,
   output logic terminal_soft_reset,
   output logic [1:0] tx_disable,
   output logic mc_rejected
);
   rtmco_state_t state;
   rtmco_state_t next_state;
   logic [15:0] cfg;
   logic lat_rt;
   logic [4:0] lat_code;
   logic lat_tr;
   logic lat_bcst;
   logic lat_bus;
   logic [15:0] lat_data;
   logic [1:0][15:0] tt_count;

   // configuration fields
   wire logic rst_opt = cfg[CFG_RST_OPT];
   wire logic vec_opt = cfg[CFG_VEC_OPT];
   wire logic [1:0] sync_load_option = cfg[CFG_SYNC_HI:CFG_SYNC_LO];
   wire logic auto_bus_shutdown_enable = cfg[CFG_ABSD];
   wire logic undefined_code_invalid = cfg[CFG_UMC];

   // undefined codes depend on the direction bit
   wire logic in_low = (mc_code <= MC_LOW_LAST);
   wire logic rx_undef = in_low || (mc_code == MC_VECTOR) || (mc_code == MC_LAST_CMD)
                         || (mc_code == MC_BIT_WORD);
   wire logic tx_undef = (mc_code == MC_SYNC_DATA) || (mc_code == MC_SHUTDOWN)
                         || (mc_code == MC_OVERRIDE);
   wire logic mc_undef = mc_tr ? tx_undef : rx_undef;
   wire logic in_idle = (state == ST_IDLE);
   wire logic take_mc = in_idle && mc_valid;
   wire logic drop_mc = take_mc && mc_undef && undefined_code_invalid;

   // decoded latched command
   wire logic in_act = (state == ST_ACT);
   wire logic is_sync = (lat_code == MC_SYNC_DATA) && !lat_tr;
   wire logic is_vector = (lat_code == MC_VECTOR) && lat_tr;
   wire logic is_reset = (lat_code == MC_RESET) && lat_tr;
   wire logic is_shut = (lat_code == MC_SHUTDOWN) && !lat_tr;
   wire logic is_ovr = (lat_code == MC_OVERRIDE) && !lat_tr;
   wire logic want_srst = is_reset && !rst_opt;

   // sync load decision
   wire logic sync_ok = (sync_load_option == SYNC_ALWAYS)
                        || ((sync_load_option == SYNC_EVEN) && !lat_data[0])
                        || ((sync_load_option == SYNC_ODD) && lat_data[0]);
   // option 00 leaves sync_ok low; status still follows below
   wire logic act_load = in_act && is_sync && sync_ok;
   wire logic [1:0] tt_load_vec = act_load ? (lat_rt ? 2'b10 : 2'b01) : 2'b00;

   // host access to the counters; protocol load wins a collision
   wire logic wr_cfg = reg_wr && (reg_addr == REG_CFG);
   wire logic wr_tt1 = reg_wr && (reg_addr == REG_TT_RT1);
   wire logic wr_tt2 = reg_wr && (reg_addr == REG_TT_RT2);
   wire logic [1:0] host_tt_vec = act_load ? 2'b00 : {wr_tt2, wr_tt1};
   wire logic [1:0] ttag_load = tt_load_vec | host_tt_vec;
   wire logic [15:0] ttag_data = act_load ? lat_data : reg_wdata;

   // shutdown acts on the other bus
   wire logic other_bus = !lat_bus;
   wire logic absd_act = in_act && auto_bus_shutdown_enable && (is_shut || is_ovr);

   // read decode
   wire logic [15:0] stat_word;
   wire logic [15:0] rd_word;
   assign stat_word = {13'h0000, !in_idle, tx_disable};
   assign rd_word = (reg_addr == REG_CFG) ? cfg
                  : (reg_addr == REG_STAT) ? stat_word
                  : (reg_addr == REG_TT_RT1) ? tt_count[0]
                  : (reg_addr == REG_TT_RT2) ? tt_count[1]
                  : ZERO_WORD;

   rtmco_ttag u_ttag (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(tt_tick),
      .load(ttag_load),
      .load_data(ttag_data),
      .count(tt_count)
   );

   // sequencing
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take_mc && !drop_mc) begin
               next_state = ST_ACT;
            end
         end
         ST_ACT: begin
            // counter and service request settle here, before status
            if (!lat_bcst) begin
               next_state = ST_STAT;
            end else if (want_srst) begin
               next_state = ST_SRST;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_STAT: begin
            next_state = want_srst ? ST_WAIT : ST_IDLE;
         end
         ST_WAIT: begin
            if (status_done) begin
               next_state = ST_SRST;
            end
         end
         ST_SRST: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         lat_rt <= 1'b0;
         lat_code <= 5'h00;
         lat_tr <= 1'b0;
         lat_bcst <= 1'b0;
         lat_bus <= 1'b0;
         lat_data <= ZERO_WORD;
      end else if (take_mc) begin
         lat_rt <= mc_rt;
         lat_code <= mc_code;
         lat_tr <= mc_tr;
         lat_bcst <= mc_broadcast;
         lat_bus <= mc_bus;
         lat_data <= mc_data;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cfg <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg <= reg_wdata & CFG_WMASK;
      end
   end

   // transmitter disables persist until an override or reset
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tx_disable <= 2'b00;
      end else if (absd_act) begin
         tx_disable[other_bus] <= is_shut;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         status_go <= 1'b0;
         srq_clear <= 1'b0;
         terminal_soft_reset <= 1'b0;
         mc_rejected <= 1'b0;
         reg_rdata <= ZERO_WORD;
      end else begin
         status_go <= (state == ST_STAT);
         srq_clear <= in_act && is_vector && !vec_opt;
         terminal_soft_reset <= (state == ST_SRST);
         mc_rejected <= drop_mc;
         reg_rdata <= reg_rd ? rd_word : ZERO_WORD;
      end
   end

   // checks
   logic [15:0] past_data;
   logic past_rt;
   logic past_load;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         past_data <= ZERO_WORD;
         past_rt <= 1'b0;
         past_load <= 1'b0;
      end else begin
         past_data <= lat_data;
         past_rt <= lat_rt;
         past_load <= act_load;
      end
   end

   sequence s_act_load;
      act_load && !lat_bcst;
   endsequence

   sequence s_status_after_load;
      ##1 (state == ST_STAT) ##1 status_go;
   endsequence

   property p_sync_always;
      @(posedge ref_clk) disable iff (reset)
      (in_act && is_sync && sync_load_option == SYNC_ALWAYS)
         |=> (tt_count[$past(lat_rt)] == $past(lat_data));
   endproperty
   a_sync_always: assert property (p_sync_always) else $error("sync option 11 did not load");

   property p_sync_none;
      @(posedge ref_clk) disable iff (reset)
      (in_act && is_sync && sync_load_option == SYNC_NONE && !lat_bcst) |-> !act_load ##2 status_go;
   endproperty
   a_sync_none: assert property (p_sync_none) else $error("sync option 00 misbehaved");

   property p_sync_even;
      @(posedge ref_clk) disable iff (reset)
      (in_act && is_sync && sync_load_option == SYNC_EVEN)
         |-> (act_load == !lat_data[0])
         ##1 ($past(lat_data[0]) || (tt_count[$past(lat_rt)] == $past(lat_data)));
   endproperty
   a_sync_even: assert property (p_sync_even) else $error("sync option 01 wrong load");

   property p_sync_odd;
      @(posedge ref_clk) disable iff (reset)
      (in_act && is_sync && sync_load_option == SYNC_ODD)
         |-> (act_load == lat_data[0])
         ##1 (!$past(lat_data[0]) || (tt_count[$past(lat_rt)] == $past(lat_data)));
   endproperty
   a_sync_odd: assert property (p_sync_odd) else $error("sync option 10 wrong load");

   property p_load_before_status;
      @(posedge ref_clk) disable iff (reset)
      s_act_load |-> !status_go ##0 s_status_after_load;
   endproperty
   a_load_before_status: assert property (p_load_before_status) else $error("status before load");

   property p_load_target;
      @(posedge ref_clk) disable iff (reset)
      past_load |-> (tt_count[past_rt] == past_data);
   endproperty
   a_load_target: assert property (p_load_target) else $error("wrong counter loaded");

   property p_no_auto_shutdown;
      @(posedge ref_clk) disable iff (reset)
      (in_act && !auto_bus_shutdown_enable) |=> $stable(tx_disable);
   endproperty
   a_no_auto_shutdown: assert property (p_no_auto_shutdown) else $error("transmitter changed");

   property p_auto_shutdown;
      @(posedge ref_clk) disable iff (reset)
      (in_act && auto_bus_shutdown_enable && (is_shut || is_ovr))
         |=> (tx_disable[!lat_bus] == $past(is_shut)) && $stable(tx_disable[lat_bus]);
   endproperty
   a_auto_shutdown: assert property (p_auto_shutdown) else $error("shutdown action wrong");

   property p_srq_clear;
      @(posedge ref_clk) disable iff (reset)
      (in_act && is_vector && !lat_bcst) |-> ##1 (srq_clear == !$past(vec_opt)) && !status_go ##1 status_go;
   endproperty
   a_srq_clear: assert property (p_srq_clear) else $error("service request clear order");

   property p_soft_reset;
      @(posedge ref_clk) disable iff (reset)
      (state == ST_WAIT && status_done) |-> !terminal_soft_reset ##2 terminal_soft_reset;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not after status");

   property p_undef_ignored;
      @(posedge ref_clk) disable iff (reset)
      (take_mc && mc_undef && undefined_code_invalid) |=> mc_rejected && in_idle ##1 !status_go [*3];
   endproperty
   a_undef_ignored: assert property (p_undef_ignored) else $error("undefined code answered");

   // broadcast commands never get a status word
   property p_bcst_silent;
      @(posedge ref_clk) disable iff (reset)
      (in_act && lat_bcst) |-> ##2 !status_go;
   endproperty
   a_bcst_silent: assert property (p_bcst_silent) else $error("status requested for broadcast");

   property p_bcst_reset;
      @(posedge ref_clk) disable iff (reset)
      (in_act && lat_bcst && want_srst) |-> ##2 terminal_soft_reset;
   endproperty
   a_bcst_reset: assert property (p_bcst_reset) else $error("broadcast soft reset missing");

   property p_reset_opt_off;
      @(posedge ref_clk) disable iff (reset)
      (in_act && is_reset && rst_opt) |=> (state != ST_SRST) ##1 (state != ST_WAIT) && (state != ST_SRST);
   endproperty
   a_reset_opt_off: assert property (p_reset_opt_off) else $error("soft reset with option set");

   property p_rdata_idle;
      @(posedge ref_clk) disable iff (reset)
      !reg_rd |=> (reg_rdata == ZERO_WORD);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule
`default_nettype wire

// [rtmco_bc_model.sv]
// bus controller model: issues received mode commands and completes status words
`timescale 1ns/1ps
`default_nettype none
module rtmco_bc_model
   import rtmco_pkg::*;
(
   input wire logic ref_clk,
   input wire logic status_go,
   output logic mc_valid,
   output logic mc_rt,
   output logic [4:0] mc_code,
   output logic mc_tr,
   output logic mc_broadcast,
   output logic mc_bus,
   output logic [15:0] mc_data,
   output logic status_done
);
   // cycles from status request to end of status word; bench varies it
   int done_delay = 1;
   int cnt = 0;

   initial begin
      mc_valid = 1'h0;
      mc_rt = 1'h0;
      mc_code = 5'h00;
      mc_tr = 1'h0;
      mc_broadcast = 1'h0;
      mc_bus = 1'h0;
      mc_data = 16'h0000;
      status_done = 1'h0;
   end

   always @(posedge ref_clk) begin
      status_done <= 1'h0;
      if (status_go === 1'h1) begin
         cnt <= done_delay;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         status_done <= 1'h1;
         cnt <= 0;
      end
   end

   task automatic send(input logic rt, input logic [4:0] code, input logic tr, input logic bc, input logic bus,
                       input logic [15:0] data);
      @(posedge ref_clk);
      mc_valid <= 1'h1;
      mc_rt <= rt;
      mc_code <= code;
      mc_tr <= tr;
      mc_broadcast <= bc;
      mc_bus <= bus;
      mc_data <= data;
      @(posedge ref_clk);
      mc_valid <= 1'h0;
      // stale word must not look like the last one
      mc_data <= ~data;
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the mode command option logic
`timescale 1ns/1ps
`default_nettype none
module testbench
   import rtmco_pkg::*;
;
   typedef struct packed {
      logic [15:0] cfg;
      logic [4:0] code;
      logic [3:0] io;
      logic [15:0] data;
      logic [15:0] tt0;
      logic [15:0] tt1;
      logic [1:0] txd;
      logic [3:0] flg;
   } rtmco_row_t;
   localparam logic [15:0] P = 16'hA5A4;
   // io = rt,tr,broadcast,bus; flg = go,srq,soft reset,rejected
   rtmco_row_t rows [21] = '{
      '{16'h000C, 5'h11, 4'h0, 16'h1235, 16'h1235, P, 2'h0, 4'h8}, '{16'h0000, 5'h11, 4'h0, 16'h1234, P, P, 2'h0, 4'h8},
      '{16'h0004, 5'h11, 4'h0, 16'h2468, 16'h2468, P, 2'h0, 4'h8}, '{16'h0004, 5'h11, 4'h0, 16'h1357, P, P, 2'h0, 4'h8},
      '{16'h0008, 5'h11, 4'h0, 16'h1357, 16'h1357, P, 2'h0, 4'h8}, '{16'h0008, 5'h11, 4'h0, 16'h2468, P, P, 2'h0, 4'h8},
      '{16'h000C, 5'h11, 4'h8, 16'hBEEF, P, 16'hBEEF, 2'h0, 4'h8}, '{16'h000C, 5'h11, 4'h2, 16'h0F0F, 16'h0F0F, P, 2'h0, 4'h0},
      '{16'h0000, 5'h14, 4'h0, 16'h0000, P, P, 2'h0, 4'h8}, '{16'h0010, 5'h14, 4'h0, 16'h0000, P, P, 2'h2, 4'h8},
      '{16'h0010, 5'h14, 4'h1, 16'h0000, P, P, 2'h3, 4'h8}, '{16'h0010, 5'h15, 4'h0, 16'h0000, P, P, 2'h1, 4'h8},
      '{16'h0010, 5'h15, 4'h1, 16'h0000, P, P, 2'h0, 4'h8}, '{16'h0200, 5'h05, 4'h0, 16'h0000, P, P, 2'h0, 4'h1},
      '{16'h020C, 5'h11, 4'h4, 16'h4321, P, P, 2'h0, 4'h1}, '{16'h000C, 5'h11, 4'h4, 16'h4321, P, P, 2'h0, 4'h8},
      '{16'h0000, 5'h10, 4'h4, 16'h0000, P, P, 2'h0, 4'hC}, '{16'h0002, 5'h10, 4'h4, 16'h0000, P, P, 2'h0, 4'h8},
      '{16'h0000, 5'h08, 4'h4, 16'h0000, P, P, 2'h0, 4'hA}, '{16'h0001, 5'h08, 4'h4, 16'h0000, P, P, 2'h0, 4'h8},
      '{16'h0000, 5'h08, 4'h6, 16'h0000, P, P, 2'h0, 4'h2}};
   logic ref_clk = 1'h0;
   logic reset = 1'h1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [1:0] tt_tick = 2'h0;
   logic [15:0] reg_rdata, mc_data, v, s;
   logic mc_valid, mc_rt, mc_tr, mc_broadcast, mc_bus, status_done;
   logic status_go, srq_clear, terminal_soft_reset, mc_rejected, watch;
   logic [4:0] mc_code;
   logic [1:0] tx_disable;
   rtmco_row_t r;
   int miscompares = 0, num_checks = 0, n_go = 0, n_srq = 0, n_srst = 0, n_rej = 0;
   int srq_at_go = 0, srst_at_go = 0, g0, q0, s0, j0;

   rtmco_top i_rtmco_top (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mc_valid(mc_valid), .mc_rt(mc_rt),
      .mc_code(mc_code), .mc_tr(mc_tr), .mc_broadcast(mc_broadcast), .mc_bus(mc_bus), .mc_data(mc_data),
      .status_done(status_done), .tt_tick(tt_tick), .status_go(status_go), .srq_clear(srq_clear),
      .terminal_soft_reset(terminal_soft_reset), .tx_disable(tx_disable), .mc_rejected(mc_rejected));
   rtmco_bc_model i_rtmco_bc_model (.ref_clk(ref_clk), .status_go(status_go), .mc_valid(mc_valid),
      .mc_rt(mc_rt), .mc_code(mc_code), .mc_tr(mc_tr), .mc_broadcast(mc_broadcast), .mc_bus(mc_bus),
      .mc_data(mc_data), .status_done(status_done));

   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
      // a following strobe goes out after this time step, never onto the release
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask

   // polls busy; a stuck block counts as a mismatch
   task automatic wait_idle(output logic [15:0] st);
      int k;
      k = 0;
      do begin
         rd(REG_STAT, st);
         k++;
      end while (st[STAT_BUSY] !== 1'h0 && k < 60);
      chk({15'h0, st[STAT_BUSY]}, 16'h0000);
      repeat (3) @(posedge ref_clk);
   endtask

   always @(posedge ref_clk) begin
      if (status_go === 1'h1) begin
         n_go++;
         srq_at_go = n_srq;
         srst_at_go = n_srst;
         if (watch === 1'h1) chk(reg_rdata, 16'h5A5A);
      end
      if (srq_clear === 1'h1) n_srq++;
      if (terminal_soft_reset === 1'h1) n_srst++;
      if (mc_rejected === 1'h1) n_rej++;
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      test_done;
   end

   initial begin
      watch = 1'h0;
      repeat (6) @(posedge ref_clk);
      reset <= 1'h0;
      @(posedge ref_clk);
      rd(REG_CFG, v);
      chk(v, CFG_RESET);
      rd(REG_TT_RT2, v);
      chk(v, TT_RESET);
      for (int i = 0; i < 21; i++) begin
         r = rows[i];
         // alternate prompt and slow status completion
         i_rtmco_bc_model.done_delay = 1 + 5 * (i % 2);
         wr(REG_CFG, r.cfg);
         wr(REG_TT_RT1, P);
         wr(REG_TT_RT2, P);
         g0 = n_go;
         q0 = n_srq;
         s0 = n_srst;
         j0 = n_rej;
         i_rtmco_bc_model.send(r.io[3], r.code, r.io[2], r.io[1], r.io[0], r.data);
         wait_idle(s);
         rd(REG_TT_RT1, v);
         chk(v, r.tt0);
         rd(REG_TT_RT2, v);
         chk(v, r.tt1);
         chk({14'h0, tx_disable}, {14'h0, r.txd});
         chk({14'h0, s[1:0]}, {14'h0, r.txd});
         chk(16'(n_go - g0), {15'h0, r.flg[3]});
         chk(16'(n_srq - q0), {15'h0, r.flg[2]});
         chk(16'(n_srst - s0), {15'h0, r.flg[1]});
         chk(16'(n_rej - j0), {15'h0, r.flg[0]});
         if (r.flg[3]) chk(16'(srst_at_go - s0), 16'h0000);
         if (r.flg[2]) chk(16'(srq_at_go - q0), 16'h0001);
      end
      wr(REG_CFG, 16'hFFFF);
      rd(8'h10, v);
      chk(v, ZERO_WORD);
      rd(REG_CFG, v);
      chk(v, CFG_WMASK);
      // nonzero read data must fall back to zero one cycle later
      @(posedge ref_clk);
      #1 chk(reg_rdata, ZERO_WORD);
      wr(REG_STAT, 16'hFFFF);
      rd(REG_STAT, v);
      chk(v, ZERO_WORD);
      // counter must already hold the new word in the cycle the status request shows
      wr(REG_CFG, 16'h000C);
      wr(REG_TT_RT1, ZERO_WORD);
      g0 = n_go;
      watch = 1'h1;
      reg_addr <= REG_TT_RT1;
      reg_rd <= 1'h1;
      i_rtmco_bc_model.send(1'h0, MC_SYNC_DATA, 1'h0, 1'h0, 1'h0, 16'h5A5A);
      repeat (4) @(posedge ref_clk);
      reg_rd <= 1'h0;
      watch = 1'h0;
      @(posedge ref_clk);
      wait_idle(s);
      chk(16'(n_go - g0), 16'h0001);
      // ticks advance only the ticked terminal's counter
      tt_tick <= 2'h1;
      repeat (3) @(posedge ref_clk);
      tt_tick <= 2'h0;
      rd(REG_TT_RT1, v);
      chk(v, 16'h5A5D);
      rd(REG_TT_RT2, v);
      chk(v, P);
      reset <= 1'h1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'h0;
      @(posedge ref_clk);
      rd(REG_CFG, v);
      chk(v, CFG_RESET);
      rd(REG_TT_RT1, v);
      chk(v, TT_RESET);
      test_done;
   end
endmodule
`default_nettype wire
